// File: logic/clock_gen_pkg.sv
package clock_gen_pkg;

  // control register field layout
  localparam int          CTL_POWER_BIT  = 5;
  localparam int          CTL_SELECT_BIT = 4;
  localparam int          CTL_EXP_LSB    = 0;
  localparam int          CTL_EXP_W      = 2;

  // register widths
  localparam int          REG_W          = 8;
  localparam int          MUL_HIGH_W     = 4;
  localparam int          MUL_W          = REG_W + MUL_HIGH_W;
  localparam int          CENTER_W       = REG_W + 3;

  // reset values
  localparam logic        POWER_RESET    = 1'b1;
  localparam logic        SELECT_RESET   = 1'b0;
  localparam logic [1:0]  EXP_RESET      = 2'h0;
  localparam logic [7:0]  MUL_LOW_RESET  = 8'h40;
  localparam logic [3:0]  MUL_HIGH_RESET = 4'h0;
  localparam logic [7:0]  RANGE_RESET    = 8'h40;

  // special values
  localparam logic [11:0] MUL_ZERO       = 12'h000;
  localparam logic [11:0] MUL_ONE        = 12'h001;
  localparam logic [7:0]  RANGE_ZERO     = 8'h00;

  // source edges counted on each side of a switch
  localparam int          SWITCH_TICKS   = 3;

  // nominal centre unit of the vco, in hertz
  localparam int          NOMINAL_UNIT_HZ = 71400;

  // source select encoding
  localparam logic        SRC_CRYSTAL    = 1'b0;
  localparam logic        SRC_VCO        = 1'b1;

  // one software write to an 8-bit register
  typedef struct packed {
    logic       strobe;
    logic [7:0] data;
  } reg_write_s;

  // switch sequencing states
  typedef enum logic [1:0] {
    SW_IDLE,
    SW_DRAIN,
    SW_FILL
  } switch_state_e;

endpackage : clock_gen_pkg

// File: logic/edge_tally.sv
`timescale 1ns/100ps
// counts source edges while enabled and flags when the target is reached
module edge_tally #(
  parameter int COUNT = 3
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // control
  input  wire logic enable,
  input  wire logic tick,
  // status
  output logic      done
);

  localparam int CW = $clog2(COUNT + 1);
  localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

  logic [CW-1:0] tally;

  ////////////////////////////////////////////////////////////////////////////
  // tally clears when disabled, stops once the target is reached
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tally <= '0;
      done  <= 1'b0;
    end else if (!enable) begin
      tally <= '0;
      done  <= 1'b0;
    end else if (tick && !done) begin
      tally <= tally + CW'(1);
      done  <= (tally == LAST);
    end
  end

endmodule : edge_tally

// File: logic/half_rate_divider.sv
`timescale 1ns/100ps
// toggles its output on every enabled edge: a divide by two
module half_rate_divider (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // source edge
  input  wire logic advance,
  // divided clock
  output logic      level
);

  ////////////////////////////////////////////////////////////////////////////
  // toggle on each passed edge, otherwise hold
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      level <= 1'b0;
    end else if (advance) begin
      level <= ~level;
    end
  end

endmodule : half_rate_divider

// File: logic/base_clock_control.sv
// Notes on behaviour
// - a feedback multiplier of zero acts exactly as one
// - linear multiplier zero disables the loop and forces the crystal source
// - a switch waits three edges of each source, output held still meanwhile
// - the switched clock is divided by two to form the base clock
// - the select bit chooses crystal or vco as the base clock source
// - vco selection is refused while loop power is off
// - loop power cannot be cleared while the vco is selected
// - one write cannot change power and selection together
// - vco frequency equals reference times the feedback multiplier
// - centre frequency is linear multiplier times two to the exponent times unit
// - oscillator and loop follow the system integration enable
// - with keep-in-stop set the oscillator runs through stop mode
// - with keep-in-stop clear the oscillator follows the enable alone, whatever stop mode says
// - reset sets loop power and clears the source select
// - exponent writes are ignored while loop power is on
`timescale 1ns/100ps
module base_clock_control #(
  parameter int SWITCH_EDGES = clock_gen_pkg::SWITCH_TICKS
) (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  // source clock edges, one-cycle enables
  input  wire logic                      crystal_clock,
  input  wire logic                      vco_clock,
  // oscillator gating
  input  wire logic                      sysint_osc_enable,
  input  wire logic                      osc_keep_in_stop,
  input  wire logic                      stop_mode,
  // register writes
  input  wire clock_gen_pkg::reg_write_s ctl_write,
  input  wire clock_gen_pkg::reg_write_s mul_low_write,
  input  wire clock_gen_pkg::reg_write_s mul_high_write,
  input  wire clock_gen_pkg::reg_write_s range_write,
  // register read back
  output logic [7:0]                     loop_control_register,
  output logic [7:0]                     multiplier_low_register,
  output logic [3:0]                     multiplier_high_register,
  output logic [7:0]                     vco_range_register,
  // derived settings for the analog loop
  output logic [11:0]                    feedback_divisor,
  output logic [10:0]                    center_scale,
  output logic                           loop_enable_out,
  output logic                           osc_run,
  // base clock and switch status
  output logic                           base_clock_out,
  output logic                           source_is_vco,
  output logic                           switching
);

  ////////////////////////////////////////////////////////////////////////////
  // control state
  logic                         loop_power_enable;
  logic                         base_source_select;
  logic [1:0]                   vco_exponent_bits;
  logic                         target_src;
  clock_gen_pkg::switch_state_e state;
  clock_gen_pkg::switch_state_e next_state;

  ////////////////////////////////////////////////////////////////////////////
  // decode of settings
  wire [11:0] mul_raw     = {multiplier_high_register, multiplier_low_register};
  wire        range_zero  = (vco_range_register == clock_gen_pkg::RANGE_ZERO);
  wire        wr_power    = ctl_write.data[clock_gen_pkg::CTL_POWER_BIT];
  wire        wr_select   = ctl_write.data[clock_gen_pkg::CTL_SELECT_BIT];
  wire [1:0]  wr_exp      = ctl_write.data[clock_gen_pkg::CTL_EXP_LSB +: clock_gen_pkg::CTL_EXP_W];

  // power may only drop while the crystal is selected
  wire        next_power  = (ctl_write.strobe && !base_source_select) ? wr_power : loop_power_enable;
  // a write that moves power leaves the selection where it is
  wire        power_moves = (next_power != loop_power_enable);
  // vco may only be taken when power is already on, stays on, and range is nonzero
  wire        may_select  = loop_power_enable && !range_zero && !power_moves;
  wire        next_select = range_zero ? clock_gen_pkg::SRC_CRYSTAL :
                            (ctl_write.strobe ? (wr_select && may_select) : base_source_select);
  // exponent locked while the loop is powered
  wire        exp_write   = ctl_write.strobe && !loop_power_enable;

  ////////////////////////////////////////////////////////////////////////////
  // control register bits
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      loop_power_enable  <= clock_gen_pkg::POWER_RESET;
      base_source_select <= clock_gen_pkg::SELECT_RESET;
      vco_exponent_bits  <= clock_gen_pkg::EXP_RESET;
    end else begin
      loop_power_enable  <= next_power;
      base_source_select <= next_select;
      if (exp_write) begin
        vco_exponent_bits <= wr_exp;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // multiplier and range registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      multiplier_low_register  <= clock_gen_pkg::MUL_LOW_RESET;
      multiplier_high_register <= clock_gen_pkg::MUL_HIGH_RESET;
      vco_range_register       <= clock_gen_pkg::RANGE_RESET;
    end else begin
      if (mul_low_write.strobe) multiplier_low_register <= mul_low_write.data;
      if (mul_high_write.strobe) multiplier_high_register <= mul_high_write.data[clock_gen_pkg::MUL_HIGH_W-1:0];
      if (range_write.strobe) vco_range_register <= range_write.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // derived settings: divisor, centre, enables
  wire [11:0] next_divisor = (mul_raw == clock_gen_pkg::MUL_ZERO) ? clock_gen_pkg::MUL_ONE : mul_raw;
  wire [10:0] next_center  = 11'({3'h0, vco_range_register} << vco_exponent_bits);
  wire        next_osc     = sysint_osc_enable || (osc_keep_in_stop && stop_mode);
  wire        next_loop_en = next_osc && loop_power_enable && !range_zero;
  wire [7:0]  next_ctl_rd  = 8'({loop_power_enable, base_source_select}) << clock_gen_pkg::CTL_SELECT_BIT
                             | 8'(vco_exponent_bits);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      feedback_divisor      <= clock_gen_pkg::MUL_ONE;
      center_scale          <= '0;
      osc_run               <= 1'b0;
      loop_enable_out       <= 1'b0;
      loop_control_register <= '0;
    end else begin
      feedback_divisor      <= next_divisor;
      center_scale          <= next_center;
      osc_run               <= next_osc;
      loop_enable_out       <= next_loop_en;
      loop_control_register <= next_ctl_rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // source edge selection: active feeds the divider, the other side is for switching
  wire active_tick = (source_is_vco == clock_gen_pkg::SRC_VCO) ? vco_clock : crystal_clock;
  wire other_tick  = (source_is_vco == clock_gen_pkg::SRC_VCO) ? crystal_clock : vco_clock;
  wire drain_done;
  wire fill_done;
  wire divider_level;
  wire pass_edge   = (state == clock_gen_pkg::SW_IDLE) && active_tick;

  // old source edges first, then new source edges
  edge_tally #(.COUNT(SWITCH_EDGES)) u_drain (
    .clk     (clk),
    .reset_n (reset_n),
    .enable  (state == clock_gen_pkg::SW_DRAIN),
    .tick    (active_tick),
    .done    (drain_done)
  );

  edge_tally #(.COUNT(SWITCH_EDGES)) u_fill (
    .clk     (clk),
    .reset_n (reset_n),
    .enable  (state == clock_gen_pkg::SW_FILL),
    .tick    (other_tick),
    .done    (fill_done)
  );

  half_rate_divider u_div (
    .clk     (clk),
    .reset_n (reset_n),
    .advance (pass_edge),
    .level   (divider_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // switch sequencer: drain old source, fill new source, then hand over
  always_comb begin
    next_state = state;
    unique case (state)
      clock_gen_pkg::SW_IDLE:  if (base_source_select != source_is_vco) next_state = clock_gen_pkg::SW_DRAIN;
      clock_gen_pkg::SW_DRAIN: if (drain_done) next_state = clock_gen_pkg::SW_FILL;
      clock_gen_pkg::SW_FILL:  if (fill_done) next_state = clock_gen_pkg::SW_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state         <= clock_gen_pkg::SW_IDLE;
      source_is_vco <= clock_gen_pkg::SRC_CRYSTAL;
      target_src    <= clock_gen_pkg::SRC_CRYSTAL;
    end else begin
      state <= next_state;
      if (state == clock_gen_pkg::SW_IDLE) target_src <= base_source_select;
      if (state == clock_gen_pkg::SW_FILL && fill_done) source_is_vco <= target_src;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output stage: divided clock and switch flag
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      base_clock_out <= 1'b0;
      switching      <= 1'b0;
    end else begin
      base_clock_out <= divider_level;
      switching      <= (next_state != clock_gen_pkg::SW_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence seq_drain_end;
    (state == clock_gen_pkg::SW_DRAIN) && drain_done;
  endsequence

  sequence seq_fill_end;
    (state == clock_gen_pkg::SW_FILL) && fill_done;
  endsequence

  AST_ZERO_MUL_IS_ONE: assert property ((mul_raw == clock_gen_pkg::MUL_ZERO) |=>
      (feedback_divisor == clock_gen_pkg::MUL_ONE))
    else $error("zero multiplier not treated as one");

  AST_RANGE_ZERO_FORCES_CRYSTAL: assert property (range_zero |=>
      (!base_source_select && !loop_enable_out))
    else $error("zero range did not force crystal and disable loop");

  AST_HOLD_DURING_SWITCH: assert property ((state != clock_gen_pkg::SW_IDLE) |=> ##1
      $stable(base_clock_out))
    else $error("base clock moved during a source switch");

  AST_DIVIDE_BY_TWO: assert property (pass_edge |=> ##1
      (base_clock_out != $past(base_clock_out)))
    else $error("base clock did not toggle once per source edge");

  AST_IGNORE_OTHER_SOURCE: assert property (!pass_edge |=> ##1 $stable(base_clock_out))
    else $error("base clock moved without an edge of the selected source");

  AST_SELECT_NEEDS_POWER: assert property ($rose(base_source_select) |->
      ($past(loop_power_enable) && loop_power_enable))
    else $error("vco selected while loop power was off");

  AST_POWER_HELD_WHILE_VCO: assert property (base_source_select |=> loop_power_enable)
    else $error("loop power cleared while vco selected");

  AST_NOT_BOTH_AT_ONCE: assert property ($changed(loop_power_enable) |->
      $stable(base_source_select))
    else $error("power and selection changed in one write");

  AST_CENTER_PRODUCT: assert property (reset_n |=> (center_scale ==
      11'({3'h0, $past(vco_range_register)} << $past(vco_exponent_bits))))
    else $error("centre scale is not range times two to the exponent");

  AST_OSC_FOLLOWS_ENABLE: assert property ((reset_n && sysint_osc_enable) |=> osc_run)
    else $error("oscillator not running with enable high");

  AST_OSC_KEPT_IN_STOP: assert property ((reset_n && osc_keep_in_stop && stop_mode) |=> osc_run)
    else $error("oscillator stopped despite keep-in-stop");

  AST_OSC_OFF_IN_STOP: assert property ((!osc_keep_in_stop && !sysint_osc_enable) |=> !osc_run)
    else $error("oscillator ran without enable");

  AST_EXP_LOCKED: assert property ((ctl_write.strobe && loop_power_enable) |=>
      $stable(vco_exponent_bits))
    else $error("exponent changed while loop powered");

  AST_DRAIN_THEN_FILL: assert property (seq_drain_end |=>
      (state == clock_gen_pkg::SW_FILL) && (source_is_vco == $past(source_is_vco)))
    else $error("drain did not hand over to fill");

  AST_HANDOVER: assert property (seq_fill_end |=>
      (state == clock_gen_pkg::SW_IDLE) && (source_is_vco == $past(target_src)))
    else $error("fill did not hand over to the new source");

  // interlock and sequencing checks: the reset_n term of AST_DIVISOR_FOLLOWS keeps the release edge out
  AST_SELECT_NEEDS_RANGE: assert property ($rose(base_source_select) |->
      !$past(range_zero))
    else $error("vco selected while range was zero");

  AST_LOOP_NEEDS_POWER: assert property (loop_enable_out |->
      ($past(loop_power_enable) && !$past(range_zero)))
    else $error("loop enabled without power or with zero range");

  AST_DIVISOR_FOLLOWS: assert property ((reset_n && (mul_raw != clock_gen_pkg::MUL_ZERO)) |=>
      (feedback_divisor == $past(mul_raw)))
    else $error("feedback divisor does not follow the multiplier");

  AST_SWITCH_FLAG: assert property (switching == (state != clock_gen_pkg::SW_IDLE))
    else $error("switch flag does not match the sequencer");

  AST_NO_SWITCH_WHEN_MATCHED: assert property (((state == clock_gen_pkg::SW_IDLE) &&
      (base_source_select == source_is_vco)) |=> (state == clock_gen_pkg::SW_IDLE))
    else $error("switch started with no change of source");

  AST_SOURCE_ONLY_AT_HANDOVER: assert property ($changed(source_is_vco) |->
      ($past(state) == clock_gen_pkg::SW_FILL))
    else $error("source changed outside the handover");

endmodule : base_clock_control

// File: testbench/sysint_partner.sv
`timescale 1ns/100ps
// system integration side: drives the oscillator enable and stop, and stands in for the two sources
module sysint_partner (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // bench controls
  input  wire logic       stop_req,
  input  wire logic [3:0] xtal_div,
  input  wire logic [3:0] vco_div,
  // towards the clock generator
  output logic            crystal_clock,
  output logic            vco_clock,
  output logic            sysint_osc_enable,
  output logic            stop_mode
);
  logic [3:0] xtal_cnt;
  logic [3:0] vco_cnt;

  ////////////////////////////////////////////////////////////////////////////////
  // enable drops while stop is requested; the sources die with it
  assign stop_mode         = stop_req;
  assign sysint_osc_enable = ~stop_req;

  ////////////////////////////////////////////////////////////////////////////////
  // one-cycle source edges at fixed divisions of clk
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      xtal_cnt      <= 4'h0;
      vco_cnt       <= 4'h0;
      crystal_clock <= 1'b0;
      vco_clock     <= 1'b0;
    end else begin
      xtal_cnt      <= (xtal_cnt >= xtal_div - 4'h1) ? 4'h0 : xtal_cnt + 4'h1;
      vco_cnt       <= (vco_cnt >= vco_div - 4'h1) ? 4'h0 : vco_cnt + 4'h1;
      crystal_clock <= sysint_osc_enable && (xtal_cnt == 4'h0);
      vco_clock     <= sysint_osc_enable && (vco_cnt == 4'h0);
    end
  end
endmodule : sysint_partner

// File: testbench/tb.sv
`timescale 1ns/100ps
module tb;
  logic clk, reset_n, crystal_clock, vco_clock, sysint_osc_enable, stop_mode, stop_req, osc_keep_in_stop;
  clock_gen_pkg::reg_write_s ctl_write, mul_low_write, mul_high_write, range_write;
  logic [7:0]  loop_control_register, multiplier_low_register, vco_range_register;
  logic [3:0]  multiplier_high_register;
  logic [11:0] feedback_divisor;
  logic [10:0] center_scale;
  logic        loop_enable_out, osc_run, base_clock_out, source_is_vco, switching;
  int          error_cnt, checked;

  ////////////////////////////////////////////////////////////////////////////////
  // design and system integration partner
  base_clock_control u_base_clock_control (.clk(clk), .reset_n(reset_n), .crystal_clock(crystal_clock),
    .vco_clock(vco_clock), .sysint_osc_enable(sysint_osc_enable), .osc_keep_in_stop(osc_keep_in_stop),
    .stop_mode(stop_mode), .ctl_write(ctl_write), .mul_low_write(mul_low_write), .mul_high_write(mul_high_write),
    .range_write(range_write), .loop_control_register(loop_control_register),
    .multiplier_low_register(multiplier_low_register), .multiplier_high_register(multiplier_high_register),
    .vco_range_register(vco_range_register), .feedback_divisor(feedback_divisor), .center_scale(center_scale),
    .loop_enable_out(loop_enable_out), .osc_run(osc_run), .base_clock_out(base_clock_out),
    .source_is_vco(source_is_vco), .switching(switching));
  sysint_partner u_sysint_partner (.clk(clk), .reset_n(reset_n), .stop_req(stop_req), .xtal_div(4'h3),
    .vco_div(4'h2), .crystal_clock(crystal_clock), .vco_clock(vco_clock),
    .sysint_osc_enable(sysint_osc_enable), .stop_mode(stop_mode));

  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick

  task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // one strobed write; returns once derived outputs have settled
  task automatic wr(input int which, input logic [7:0] d);
    @(posedge clk);
    case (which)
      0: ctl_write <= '{1'b1, d};
      1: mul_low_write <= '{1'b1, d};
      2: mul_high_write <= '{1'b1, d};
      default: range_write <= '{1'b1, d};
    endcase
    @(posedge clk);
    ctl_write.strobe <= 1'b0;
    mul_low_write.strobe <= 1'b0;
    mul_high_write.strobe <= 1'b0;
    range_write.strobe <= 1'b0;
    @(posedge clk);
    tick();
  endtask : wr

  // every source edge in idle toggles the base clock two cycles on, no other edge does
  task automatic verify_divide(input logic vco);
    logic h0, h1, prev;
    h0 = 1'b0;
    h1 = 1'b0;
    prev = base_clock_out;
    for (int i = 0; i < 24; i++) begin
      tick();
      if (i >= 2) check("divide", {11'h0, base_clock_out ^ prev}, {11'h0, h1});
      h1 = h0;
      h0 = vco ? vco_clock : crystal_clock;
      prev = base_clock_out;
    end
  endtask : verify_divide

  // a switch holds the output still and consumes three edges of each source
  task automatic s_switch(input logic to_vco);
    int n, xc, vc;
    logic held, b0;
    n = 0;
    while (switching !== 1'b1 && n < 10) begin
      tick();
      n++;
    end
    check("switch_start", {11'h0, switching}, 12'h001);
    tick();
    b0 = base_clock_out;
    held = 1'b1;
    xc = 0;
    vc = 0;
    while (switching === 1'b1 && n < 80) begin
      held &= (base_clock_out === b0);
      xc += crystal_clock;
      vc += vco_clock;
      tick();
      n++;
    end
    check("held", {11'h0, held}, 12'h001);
    check("switch_end", {11'h0, switching}, 12'h000);
    check("edges_both", {11'h0, (xc >= 3) && (vc >= 3)}, 12'h001);
    check("source", {11'h0, source_is_vco}, {11'h0, to_vco});
  endtask : s_switch

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic s_reset();
    check("ctl_reset", loop_control_register, 12'h020);
    check("mul_reset", {multiplier_high_register, multiplier_low_register}, 12'h040);
    check("range_reset", vco_range_register, 12'h040);
    check("src_reset", {11'h0, source_is_vco}, 12'h000);
    check("loop_on", {11'h0, loop_enable_out}, 12'h001);
    verify_divide(1'b0);
  endtask : s_reset

  task automatic s_mult();
    wr(1, 8'h00);
    wr(2, 8'h00);
    check("mul_zero", feedback_divisor, 12'h001);
    wr(1, 8'h1c);
    check("mul_low", feedback_divisor, 12'h01c);
    wr(2, 8'h05);
    check("mul_split", feedback_divisor, 12'h51c);
  endtask : s_mult

  task automatic s_exp();
    wr(0, 8'h22);
    check("exp_locked", loop_control_register, 12'h020);
    wr(0, 8'h00);
    check("power_off", {loop_control_register[7:0], 3'h0, loop_enable_out}, 12'h000);
    wr(0, 8'h02);
    check("exp_open", loop_control_register, 12'h002);
    wr(3, 8'h46);
    check("center", center_scale, 12'h118);
  endtask : s_exp

  task automatic s_interlock();
    wr(0, 8'h32);
    check("one_write", loop_control_register, 12'h022);
    wr(0, 8'h32);
    check("select_on", loop_control_register, 12'h032);
    s_switch(1'b1);
    verify_divide(1'b1);
    wr(0, 8'h12);
    check("power_kept", loop_control_register, 12'h032);
    wr(3, 8'h00);
    check("range_zero", {loop_control_register[7:0], 3'h0, loop_enable_out}, 12'h220);
    s_switch(1'b0);
    verify_divide(1'b0);
    wr(0, 8'h32);
    check("range_refuse", loop_control_register, 12'h022);
    wr(3, 8'h46);
  endtask : s_interlock

  task automatic s_osc();
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      stop_req <= k[0];
      osc_keep_in_stop <= k[1];
      repeat (2) @(posedge clk);
      tick();
      check("osc_run", {11'h0, osc_run}, {11'h0, !k[0] || k[1]});
    end
  endtask : s_osc

  ////////////////////////////////////////////////////////////////////////////////
  // closing
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////////////
  // clock, watchdog and main sequence
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #100000;
    error_cnt++;
    report_and_stop();
  end

  initial begin
    error_cnt = 0;
    checked = 0;
    reset_n = 1'b0;
    stop_req = 1'b0;
    osc_keep_in_stop = 1'b0;
    ctl_write = '0;
    mul_low_write = '0;
    mul_high_write = '0;
    range_write = '0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) tick();
    s_reset();
    s_mult();
    s_exp();
    s_interlock();
    s_osc();
    report_and_stop();
  end
endmodule : tb
